// ===== drop_bus_aligner_pkg.sv
// Constants, types and register layout of the drop bus aligner control.
package drop_bus_aligner_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CONTROL = 8'h28;
    localparam logic [7:0] IDX_STATUS_DIAG = 8'h29;
    localparam logic [7:0] IDX_ISF = 8'h2A;
    localparam int ADDR_W = 12;

    // Field positions of the aligner control register.
    localparam int CTL_FORCE_AIS = 0;
    localparam int CTL_JUSTIFY_IE = 1;
    localparam int CTL_STORE_IE = 2;
    localparam int CTL_SIGNAL_FAIL_IE = 3;
    localparam int CTL_SIZE_SEL = 4;
    localparam int CTL_CLEAR_STUFF = 5;
    localparam int CTL_H4_BYPASS = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h10;

    // Field positions of the interrupt status and diagnostic register.
    localparam int ST_POINTER_LOSS = 0;
    localparam int ST_NEG_JUSTIFY = 1;
    localparam int ST_POS_JUSTIFY = 2;
    localparam int ST_STORE_ERROR = 3;
    localparam int ST_DEPTH_LO = 4;
    localparam int ST_DIAG_LO = 6;
    localparam logic [7:0] STATUS_DIAG_RESET = 8'h20;

    // Field positions of the signal failure register.
    localparam int ISF_STATE_BIT = 7;
    localparam int ISF_CHANGE_BIT = 6;

    // Byte values placed on the drop bus.
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZEROS = 8'h00;
    localparam logic [7:0] H4_SEQ_BASE = 8'hFC;
    localparam logic [1:0] SIZE_BITS_SET = 2'h2;
    localparam logic [1:0] SIZE_BITS_CLEAR = 2'h0;
    localparam int NDF_HI = 7;
    localparam int NDF_LO = 4;
    localparam int SIZE_HI = 3;
    localparam int SIZE_LO = 2;

    // Justification diagnostic codes.
    localparam logic [1:0] DIAG_NORMAL = 2'h0;
    localparam logic [1:0] DIAG_FORCE_NEG = 2'h1;
    localparam logic [1:0] DIAG_FORCE_POS = 2'h2;
    localparam logic [1:0] DIAG_DISABLE = 2'h3;

    // Frame spacing of justifications, stored as period minus one.
    localparam logic [3:0] SOFT_PERIOD_M1 = 4'hF;
    localparam logic [3:0] HARD_PERIOD_M1 = 4'h3;
    localparam logic [3:0] DIAG_PERIOD_M1 = 4'h3;

    // Fill limits indexed by the depth select code.
    localparam logic [3:0][3:0] HARD_NEG_LIMIT = {4'h7, 4'h6, 4'h5, 4'h4};
    localparam logic [3:0][3:0] SOFT_NEG_LIMIT = {4'h6, 4'h4, 4'h1, 4'h0};
    localparam logic [3:0][3:0] SOFT_POS_LIMIT = {4'h6, 4'h4, 4'h1, 4'h0};
    localparam logic [3:0][3:0] HARD_POS_LIMIT = {4'h7, 4'h6, 4'h4, 4'h4};

    // Fill region of the elastic store.
    typedef enum logic [4:0] {
        REGION_CENTRE = 5'b00001,
        REGION_SOFT_POS = 5'b00010,
        REGION_HARD_POS = 5'b00100,
        REGION_SOFT_NEG = 5'b01000,
        REGION_HARD_NEG = 5'b10000
    } fill_region_t;

    // One byte of the stream together with its position markers.
    typedef struct packed {
        logic [7:0] data;
        logic frame_start;
        logic is_h1;
        logic is_h2;
        logic is_h3;
        logic is_h4;
        logic is_spe;
        logic is_fixed_stuff;
        logic [1:0] mf_phase;
    } stream_beat_t;

endpackage

// ===== justify_pacer.sv
// Frame pacer that spaces outgoing pointer justifications.
module justify_pacer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_tick,
    input wire drop_bus_aligner_pkg::fill_region_t region,
    input wire logic [1:0] diag_code,
    output logic pos_pulse,
    output logic neg_pulse
);

    logic [3:0] frames_q;
    logic [3:0] frames_d;
    logic pos_q;
    logic pos_d;
    logic neg_q;
    logic neg_d;
    logic want_pos;
    logic want_neg;
    logic [3:0] period_m1;

    // Pick direction and spacing; diagnostic codes override the fill level.
    always_comb begin
        want_pos = 1'b0;
        want_neg = 1'b0;
        period_m1 = drop_bus_aligner_pkg::SOFT_PERIOD_M1;
        case (diag_code)
            drop_bus_aligner_pkg::DIAG_FORCE_POS: begin
                want_pos = 1'b1;
                period_m1 = drop_bus_aligner_pkg::DIAG_PERIOD_M1;
            end
            drop_bus_aligner_pkg::DIAG_FORCE_NEG: begin
                want_neg = 1'b1;
                period_m1 = drop_bus_aligner_pkg::DIAG_PERIOD_M1;
            end
            drop_bus_aligner_pkg::DIAG_DISABLE: begin
                want_pos = 1'b0;
            end
            default: begin
                case (region)
                    drop_bus_aligner_pkg::REGION_SOFT_POS: want_pos = 1'b1;
                    drop_bus_aligner_pkg::REGION_SOFT_NEG: want_neg = 1'b1;
                    drop_bus_aligner_pkg::REGION_HARD_POS: begin
                        want_pos = 1'b1;
                        period_m1 = drop_bus_aligner_pkg::HARD_PERIOD_M1;
                    end
                    drop_bus_aligner_pkg::REGION_HARD_NEG: begin
                        want_neg = 1'b1;
                        period_m1 = drop_bus_aligner_pkg::HARD_PERIOD_M1;
                    end
                    default: want_pos = 1'b0;
                endcase
            end
        endcase
    end

    // Count frames since the last justification and fire once per period.
    always_comb begin
        frames_d = frames_q;
        pos_d = 1'b0;
        neg_d = 1'b0;
        if (frame_tick) begin
            if (!(want_pos || want_neg)) begin
                frames_d = 4'h0;
            end else if (frames_q >= period_m1) begin
                frames_d = 4'h0;
                pos_d = want_pos;
                neg_d = want_neg;
            end else begin
                frames_d = frames_q + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_q <= 4'h0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            frames_q <= frames_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
        end
    end

    assign pos_pulse = pos_q;
    assign neg_pulse = neg_q;

endmodule // justify_pacer

// ===== drop_bus_aligner_control.sv
// Drop bus aligner control, interrupt status and byte rewriting.
// How it works
// - Force path AIS makes pointer bytes and whole payload all ones.
// - Forced path AIS raises far-end failure to alarm port and transmitter.
// - Justification events raise the interrupt only when enabled.
// - Store overflow or underflow raises the interrupt only when enabled.
// - Any change of incoming signal failure raises interrupt when enabled.
// - Size bits in H1 are 10 when selected, else 00.
// - Clear stuff bit zeroes fixed stuff columns, else passes them.
// - Without bypass, H4 becomes FC to FF following multiframe phase.
// - Pointer loss diagnostic inverts new data flag of inserted pointers.
// - Negative justify status bit sets on each inserted negative event.
// - Positive justify status bit sets on each inserted positive event.
// - Store error status bit sets on FIFO overflow or underflow.
// - Reading status register clears its interrupt bits and interrupt.
// - Depth field picks limits; soft justifies per 16, hard per 4 frames.
// - Diagnostic code forces or stops justification; nonzero hides errors.
//
// Added by the designer: register access over APB.
module drop_bus_aligner_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drop_bus_aligner_pkg::stream_beat_t rx_beat,
    input wire logic signed [3:0] fifo_fill_offset,
    input wire logic fifo_flow_error,
    input wire logic isf_state,
    output drop_bus_aligner_pkg::stream_beat_t drop_beat,
    output logic justify_pos,
    output logic justify_neg,
    output logic path_ferf_alarm,
    output logic path_ferf_to_transmit,
    output logic irq_out_n
);

    // Byte address of a register from its index.
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // Magnitude of the signed fill offset.
    function automatic logic [3:0] magnitude(input logic signed [3:0] v);
        return v[3] ? 4'(-v) : 4'(v);
    endfunction

    logic [7:0] control_q;
    logic [7:0] control_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:6] isf_reg_q;
    logic [7:6] isf_reg_d;
    logic isf_prev_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    drop_bus_aligner_pkg::stream_beat_t drop_q;
    drop_bus_aligner_pkg::stream_beat_t drop_d;
    drop_bus_aligner_pkg::fill_region_t region;

    logic setup_phase;
    logic access_phase;
    logic hit_control;
    logic hit_status;
    logic hit_isf;
    logic mapped;
    logic wr_control;
    logic wr_status;
    logic wr_isf;
    logic rd_status;
    logic rd_isf;
    logic pos_evt;
    logic neg_evt;
    logic flow_evt;
    logic isf_evt;
    logic [1:0] depth_sel;
    logic [1:0] diag_code;
    logic [3:0] fill_mag;
    logic irq_any;

    // Address decode; only aligned word addresses are mapped.
    always_comb begin
        setup_phase = psel && !penable;
        access_phase = psel && penable;
        hit_control = paddr == reg_addr(drop_bus_aligner_pkg::IDX_CONTROL);
        hit_status = paddr == reg_addr(drop_bus_aligner_pkg::IDX_STATUS_DIAG);
        hit_isf = paddr == reg_addr(drop_bus_aligner_pkg::IDX_ISF);
        mapped = hit_control || hit_status || hit_isf;
        wr_control = access_phase && pwrite && hit_control;
        wr_status = access_phase && pwrite && hit_status;
        wr_isf = access_phase && pwrite && hit_isf;
        rd_status = access_phase && !pwrite && hit_status;
        rd_isf = access_phase && !pwrite && hit_isf;
    end

    // Zero wait states; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = access_phase && !mapped;

    assign depth_sel = status_q[drop_bus_aligner_pkg::ST_DEPTH_LO +: 2];
    assign diag_code = status_q[drop_bus_aligner_pkg::ST_DIAG_LO +: 2];
    assign fill_mag = magnitude(fifo_fill_offset);

    // Classify the store fill against the limits of the depth code.
    always_comb begin
        region = drop_bus_aligner_pkg::REGION_CENTRE;
        if (!fifo_fill_offset[3]) begin
            if (fill_mag >
                drop_bus_aligner_pkg::HARD_POS_LIMIT[depth_sel]) begin
                region = drop_bus_aligner_pkg::REGION_HARD_POS;
            end else if (fill_mag >
                         drop_bus_aligner_pkg::SOFT_POS_LIMIT[depth_sel]) begin
                region = drop_bus_aligner_pkg::REGION_SOFT_POS;
            end
        end else begin
            if (fill_mag >
                drop_bus_aligner_pkg::HARD_NEG_LIMIT[depth_sel]) begin
                region = drop_bus_aligner_pkg::REGION_HARD_NEG;
            end else if (fill_mag >
                         drop_bus_aligner_pkg::SOFT_NEG_LIMIT[depth_sel]) begin
                region = drop_bus_aligner_pkg::REGION_SOFT_NEG;
            end
        end
    end

    // Justifications are paced per frame by the pacer.
    justify_pacer justify_pacer_inst (
        .pclk(pclk),
        .presetn(presetn),
        .frame_tick(rx_beat.frame_start),
        .region(region),
        .diag_code(diag_code),
        .pos_pulse(pos_evt),
        .neg_pulse(neg_evt)
    );

    assign justify_pos = pos_evt;
    assign justify_neg = neg_evt;

    // A diagnostic code other than normal hides flow errors on purpose,
    // since forced justification is expected to spill the store.
    assign flow_evt = fifo_flow_error &&
                      (diag_code == drop_bus_aligner_pkg::DIAG_NORMAL);
    assign isf_evt = isf_state != isf_prev_q;

    // Control register; the reserved bit is stored as written.
    always_comb begin
        control_d = control_q;
        if (wr_control) begin
            control_d = pwdata[7:0];
        end
    end

    // Status and diagnostic register. A read clears only the bits that
    // the read returned, so an event landing between setup and access
    // is kept for the next read. Any new event wins over a clear.
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d[7:4] = pwdata[7:4];
            status_d[0] = pwdata[0];
            status_d[3:1] = status_q[3:1] & ~pwdata[3:1];
        end
        if (rd_status) begin
            status_d[3:1] = status_d[3:1] & ~prdata_q[3:1];
        end
        if (neg_evt) begin
            status_d[drop_bus_aligner_pkg::ST_NEG_JUSTIFY] = 1'b1;
        end
        if (pos_evt) begin
            status_d[drop_bus_aligner_pkg::ST_POS_JUSTIFY] = 1'b1;
        end
        if (flow_evt) begin
            status_d[drop_bus_aligner_pkg::ST_STORE_ERROR] = 1'b1;
        end
    end

    // Signal failure register: live state plus sticky change flag.
    always_comb begin
        isf_reg_d = isf_reg_q;
        isf_reg_d[drop_bus_aligner_pkg::ISF_STATE_BIT] = isf_state;
        if (wr_isf && pwdata[drop_bus_aligner_pkg::ISF_CHANGE_BIT]) begin
            isf_reg_d[drop_bus_aligner_pkg::ISF_CHANGE_BIT] = 1'b0;
        end
        if (rd_isf && prdata_q[drop_bus_aligner_pkg::ISF_CHANGE_BIT]) begin
            isf_reg_d[drop_bus_aligner_pkg::ISF_CHANGE_BIT] = 1'b0;
        end
        if (isf_evt) begin
            isf_reg_d[drop_bus_aligner_pkg::ISF_CHANGE_BIT] = 1'b1;
        end
    end

    // Read data is captured in the setup phase and held for the access.
    always_comb begin
        prdata_d = prdata_q;
        if (setup_phase) begin
            prdata_d = 32'h0000_0000;
            if (hit_control) begin
                prdata_d[7:0] = control_q;
            end else if (hit_status) begin
                prdata_d[7:0] = status_q;
            end else if (hit_isf) begin
                prdata_d[7:6] = isf_reg_q;
            end
        end
    end

    // Rewrite the stream byte; path AIS is applied last so it wins.
    always_comb begin
        drop_d = rx_beat;
        if (rx_beat.is_h1) begin
            if (status_q[drop_bus_aligner_pkg::ST_POINTER_LOSS]) begin
                drop_d.data[drop_bus_aligner_pkg::NDF_HI:
                            drop_bus_aligner_pkg::NDF_LO] =
                    ~rx_beat.data[drop_bus_aligner_pkg::NDF_HI:
                                  drop_bus_aligner_pkg::NDF_LO];
            end
            drop_d.data[drop_bus_aligner_pkg::SIZE_HI:
                        drop_bus_aligner_pkg::SIZE_LO] =
                control_q[drop_bus_aligner_pkg::CTL_SIZE_SEL] ?
                drop_bus_aligner_pkg::SIZE_BITS_SET :
                drop_bus_aligner_pkg::SIZE_BITS_CLEAR;
        end
        if (rx_beat.is_h4 &&
            !control_q[drop_bus_aligner_pkg::CTL_H4_BYPASS]) begin
            drop_d.data = drop_bus_aligner_pkg::H4_SEQ_BASE |
                          {6'h00, rx_beat.mf_phase};
        end
        if (rx_beat.is_fixed_stuff &&
            control_q[drop_bus_aligner_pkg::CTL_CLEAR_STUFF]) begin
            drop_d.data = drop_bus_aligner_pkg::ALL_ZEROS;
        end
        if (control_q[drop_bus_aligner_pkg::CTL_FORCE_AIS] &&
            (rx_beat.is_h1 || rx_beat.is_h2 || rx_beat.is_h3 ||
             rx_beat.is_h4 || rx_beat.is_spe || rx_beat.is_fixed_stuff)) begin
            drop_d.data = drop_bus_aligner_pkg::ALL_ONES;
        end
    end

    // Enabled status bits gate onto the single interrupt line.
    always_comb begin
        irq_any = (status_q[drop_bus_aligner_pkg::ST_NEG_JUSTIFY] ||
                   status_q[drop_bus_aligner_pkg::ST_POS_JUSTIFY]) &&
                  control_q[drop_bus_aligner_pkg::CTL_JUSTIFY_IE];
        irq_any = irq_any ||
                  (status_q[drop_bus_aligner_pkg::ST_STORE_ERROR] &&
                   control_q[drop_bus_aligner_pkg::CTL_STORE_IE]);
        irq_any = irq_any ||
                  (isf_reg_q[drop_bus_aligner_pkg::ISF_CHANGE_BIT] &&
                   control_q[drop_bus_aligner_pkg::CTL_SIGNAL_FAIL_IE]);
    end

    assign irq_out_n = !irq_any;

    // Register every group of state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= drop_bus_aligner_pkg::CONTROL_RESET;
            status_q <= drop_bus_aligner_pkg::STATUS_DIAG_RESET;
            isf_reg_q <= 2'h0;
            isf_prev_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            drop_q <= '0;
        end else begin
            control_q <= control_d;
            status_q <= status_d;
            isf_reg_q <= isf_reg_d;
            isf_prev_q <= isf_state;
            prdata_q <= prdata_d;
            drop_q <= drop_d;
        end
    end

    assign prdata = prdata_q;
    assign drop_beat = drop_q;
    // Far-end failure follows the registered force bit directly.
    assign path_ferf_alarm =
        control_q[drop_bus_aligner_pkg::CTL_FORCE_AIS];
    assign path_ferf_to_transmit =
        control_q[drop_bus_aligner_pkg::CTL_FORCE_AIS];

endmodule // drop_bus_aligner_control

// ===== drop_bus_aligner_control_props.sv
// Port-level checker for the drop bus aligner control block.
module drop_bus_aligner_control_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire drop_bus_aligner_pkg::stream_beat_t rx_beat,
    input wire logic fifo_flow_error,
    input wire logic isf_state,
    input wire drop_bus_aligner_pkg::stream_beat_t drop_beat,
    input wire logic justify_pos,
    input wire logic justify_neg,
    input wire logic path_ferf_alarm,
    input wire logic path_ferf_to_transmit,
    input wire logic irq_out_n
);
    logic [7:0] ctl_q, ctl_d, sts_q, sts_d;
    logic wr_ok;
    // Shadow the writable bits so each check knows the live settings.
    assign wr_ok = psel && penable && pwrite && pready;
    always_comb begin
        ctl_d = (wr_ok && paddr == 12'h0A0) ? pwdata[7:0] : ctl_q;
        sts_d = (wr_ok && paddr == 12'h0A4) ? pwdata[7:0] : sts_q;
    end
    // The shadow resets to the same values as the block's registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= drop_bus_aligner_pkg::CONTROL_RESET;
            sts_q <= drop_bus_aligner_pkg::STATUS_DIAG_RESET;
        end else begin
            ctl_q <= ctl_d;
            sts_q <= sts_d;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ais_all_ones: assert property (ctl_q[0] && (rx_beat.is_h1 ||
        rx_beat.is_h2 || rx_beat.is_h3 || rx_beat.is_spe)
        |=> drop_beat.data == 8'hFF) else $error("AIS byte not all ones.");
    a_ferf_follows: assert property (path_ferf_alarm == ctl_q[0] &&
        path_ferf_to_transmit == ctl_q[0]) else $error("FERF mismatch.");
    a_justify_irq: assert property ((justify_pos || justify_neg) &&
        ctl_q[1] |=> !irq_out_n) else $error("Justify irq missing.");
    a_flow_irq: assert property (fifo_flow_error && ctl_q[2] &&
        sts_q[7:6] == 2'b00 |-> ##[1:2] !irq_out_n)
        else $error("Flow error irq missing.");
    a_isf_irq: assert property (ctl_q[3] && $changed(isf_state)
        |-> ##[1:2] !irq_out_n) else $error("Signal fail irq missing.");
    a_size_bits: assert property (!ctl_q[0] && rx_beat.is_h1
        |=> drop_beat.data[3:2] == {$past(ctl_q[4]), 1'b0})
        else $error("Size bits wrong.");
    a_stuff_zero: assert property (!ctl_q[0] && ctl_q[5] &&
        rx_beat.is_fixed_stuff |=> drop_beat.data == 8'h00)
        else $error("Stuff byte not cleared.");
    a_h4_sequence: assert property (!ctl_q[0] && !ctl_q[6] &&
        rx_beat.is_h4 |=> drop_beat.data == {6'h3F,
        $past(rx_beat.mf_phase)}) else $error("H4 sequence wrong.");
    a_h4_bypass: assert property (!ctl_q[0] && ctl_q[6] &&
        rx_beat.is_h4 |=> drop_beat.data == $past(rx_beat.data))
        else $error("H4 not passed.");
    a_ndf_invert: assert property (!ctl_q[0] && sts_q[0] &&
        rx_beat.is_h1 |=> drop_beat.data[7:4] ==
        ~$past(rx_beat.data[7:4])) else $error("NDF not inverted.");
    a_irq_cause: assert property (!irq_out_n |->
        ctl_q[1] || ctl_q[2] || ctl_q[3]) else $error("Irq without enable.");
    c_justify: cover property (justify_pos ##1 !irq_out_n);
    c_flow: cover property (fifo_flow_error && ctl_q[2]);
    c_isf: cover property ($changed(isf_state) && ctl_q[3]);
endmodule // drop_bus_aligner_control_props

bind drop_bus_aligner_control drop_bus_aligner_control_props
    drop_bus_aligner_control_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .rx_beat(rx_beat),
    .fifo_flow_error(fifo_flow_error), .isf_state(isf_state),
    .drop_beat(drop_beat), .justify_pos(justify_pos),
    .justify_neg(justify_neg), .path_ferf_alarm(path_ferf_alarm),
    .path_ferf_to_transmit(path_ferf_to_transmit), .irq_out_n(irq_out_n));

// ===== drop_sink.sv
// Downstream pointer tracker model that counts the justify_pos and justify_neg pulses.
module drop_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic justify_pos,
    input wire logic justify_neg,
    output logic [7:0] pos_q,
    output logic [7:0] neg_q
);
    // Count outgoing justifications as a downstream tracker would see them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 8'h00;
            neg_q <= 8'h00;
        end else begin
            pos_q <= pos_q + {7'h00, justify_pos};
            neg_q <= neg_q + {7'h00, justify_neg};
        end
    end
endmodule // drop_sink

// ===== tb_drop_bus_aligner_control.sv
// Self-checking bench for the drop bus aligner control block.
module tb_drop_bus_aligner_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_CTL = 12'h0A0;
    localparam logic [11:0] A_STS = 12'h0A4;
    localparam logic [11:0] A_ISF = 12'h0A8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
    logic fifo_flow_error, isf_state, justify_pos, justify_neg, irq_out_n;
    logic path_ferf_alarm, path_ferf_to_transmit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic signed [3:0] fifo_fill_offset;
    logic [7:0] pos_q, neg_q;
    drop_bus_aligner_pkg::stream_beat_t rx_beat, drop_beat;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    drop_bus_aligner_control drop_bus_aligner_control_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_beat(rx_beat),
        .fifo_fill_offset(fifo_fill_offset),
        .fifo_flow_error(fifo_flow_error), .isf_state(isf_state),
        .drop_beat(drop_beat), .justify_pos(justify_pos),
        .justify_neg(justify_neg), .path_ferf_alarm(path_ferf_alarm),
        .path_ferf_to_transmit(path_ferf_to_transmit), .irq_out_n(irq_out_n));
    drop_sink drop_sink_inst (.pclk(pclk), .presetn(presetn),
        .justify_pos(justify_pos), .justify_neg(justify_neg),
        .pos_q(pos_q), .neg_q(neg_q));

    // Free-running 10 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Prints the tallies and the verdict, then stops the run.
    task complete_run();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdv, exp);
    endtask

    // Sends one marked byte and compares what leaves on the drop bus.
    task push(input int k, input logic [7:0] d, input logic [1:0] ph,
              input logic [7:0] exp);
        drop_bus_aligner_pkg::stream_beat_t b;
        b = '0;
        b.data = d;
        b.mf_phase = ph;
        b.is_h1 = (k == 0);
        b.is_h4 = (k == 1);
        b.is_fixed_stuff = (k == 2);
        b.is_spe = (k == 3);
        rx_beat <= b;
        @(posedge pclk);
        rx_beat <= '0;
        @(negedge pclk);
        check({24'h0, drop_beat.data}, {24'h0, exp});
        @(posedge pclk);
    endtask

    // Runs n frames and compares the justifications the sink counted.
    task frames(input int n, input logic [7:0] pe, input logic [7:0] ne);
        logic [7:0] p0, n0;
        drop_bus_aligner_pkg::stream_beat_t fb;
        p0 = pos_q;
        n0 = neg_q;
        fb = '0;
        fb.frame_start = 1'b1;
        repeat (n) begin
            rx_beat <= fb;
            @(posedge pclk);
            rx_beat <= '0;
            repeat (3) @(posedge pclk);
        end
        check({16'h0, pos_q - p0, neg_q - n0}, {16'h0, pe, ne});
    endtask

    // Irq is combinational, so it is sampled mid-cycle.
    task irq(input logic exp_n);
        @(negedge pclk);
        check({31'h0, irq_out_n}, {31'h0, exp_n});
        @(posedge pclk);
    endtask

    task flow();
        fifo_flow_error <= 1'b1;
        @(posedge pclk);
        fifo_flow_error <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, fifo_flow_error, isf_state, paddr,
            pwdata, rx_beat, fifo_fill_offset} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_CTL, 32'h10);
        rd(A_STS, 32'h20);
        apb(1'b1, 12'h0AC, 32'hFF);
        check({31'h0, errv}, 32'h1);
        push(0, 8'h6A, 2'h0, 8'h6A);
        apb(1'b1, A_CTL, 32'h00);
        push(0, 8'h6A, 2'h0, 8'h62);
        for (int p = 0; p < 4; p++) push(1, 8'h5A, 2'(p), 8'hFC | 8'(p));
        push(2, 8'h33, 2'h0, 8'h33);
        apb(1'b1, A_CTL, 32'h60);
        push(2, 8'h33, 2'h0, 8'h00);
        push(1, 8'h5A, 2'h1, 8'h5A);
        apb(1'b1, A_STS, 32'h21);
        push(0, 8'h6A, 2'h0, 8'h92);
        apb(1'b1, A_STS, 32'h20);
        apb(1'b1, A_CTL, 32'h01);
        push(0, 8'h6A, 2'h0, 8'hFF);
        push(3, 8'h12, 2'h0, 8'hFF);
        check({30'h0, path_ferf_alarm, path_ferf_to_transmit}, 32'h3);
        apb(1'b1, A_CTL, 32'h02);
        push(3, 8'h12, 2'h0, 8'h12);
        check({30'h0, path_ferf_alarm, path_ferf_to_transmit}, 32'h0);
        apb(1'b1, A_STS, 32'hA0);
        frames(8, 8'd2, 8'd0);
        irq(1'b0);
        rd(A_STS, 32'hA4);
        irq(1'b1);
        apb(1'b1, A_CTL, 32'h00);
        apb(1'b1, A_STS, 32'h60);
        frames(8, 8'd0, 8'd2);
        irq(1'b1);
        rd(A_STS, 32'h62);
        apb(1'b1, A_STS, 32'hE0);
        frames(8, 8'd0, 8'd0);
        apb(1'b1, A_STS, 32'h20);
        fifo_fill_offset <= 4'sd7;
        frames(8, 8'd2, 8'd0);
        fifo_fill_offset <= 4'sd5;
        frames(16, 8'd1, 8'd0);
        fifo_fill_offset <= -4'sd7;
        frames(8, 8'd0, 8'd2);
        fifo_fill_offset <= 4'sd0;
        frames(8, 8'd0, 8'd0);
        rd(A_STS, 32'h26);
        apb(1'b1, A_CTL, 32'h04);
        flow();
        irq(1'b0);
        rd(A_STS, 32'h28);
        irq(1'b1);
        apb(1'b1, A_STS, 32'h60);
        flow();
        irq(1'b1);
        rd(A_STS, 32'h60);
        apb(1'b1, A_CTL, 32'h08);
        isf_state <= 1'b1;
        repeat (2) @(posedge pclk);
        irq(1'b0);
        rd(A_ISF, 32'hC0);
        irq(1'b1);
        isf_state <= 1'b0;
        repeat (2) @(posedge pclk);
        irq(1'b0);
        rd(A_ISF, 32'h40);
        complete_run();
    end
endmodule // tb_drop_bus_aligner_control
